// *** nvac_pkg.sv ***
// shared constants for the byte-wide nonvolatile store controller
package nvac_pkg;
    // --------------------------------------------------------------
    // device-side i/o register indices
    // --------------------------------------------------------------
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_ADDRL = 2'h2;
    localparam logic [1:0] REG_ADDRH = 2'h3;
    // control register fields
    localparam logic [7:0] CTRL_RE_M = 8'h01;
    localparam logic [7:0] CTRL_PE_M = 8'h02;
    localparam logic [7:0] CTRL_ME_M = 8'h04;
    localparam int CTRL_PM_LSB = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // programming modes
    localparam logic [1:0] PM_ATOMIC = 2'h0;
    localparam logic [1:0] PM_ERASE = 2'h1;
    localparam logic [1:0] PM_WRITE = 2'h2;
    localparam logic [1:0] PM_RSVD = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // --------------------------------------------------------------
    // timing in clk_sys cycles
    // --------------------------------------------------------------
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] WRITE_STALL = 3'h2;
    localparam logic [2:0] ME_WINDOW = 3'h4;
    // --------------------------------------------------------------
    // controller apb map
    // --------------------------------------------------------------
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STAT = 12'h004;
    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_RD_BIT = 2;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DATA_LSB = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RBYTE_LSB = 8;
endpackage

// *** nvac_if.sv ***
// i/o register link between the controller and the store
`timescale 1ns/1ps
`default_nettype none
interface nvac_if;
    logic [1:0] io_sel;
    logic io_we;
    logic io_re;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic cpu_stall;
    modport dev(input io_sel, input io_we, input io_re, input io_wdata,
                output io_rdata, output cpu_stall);
    modport host(output io_sel, output io_we, output io_re, output io_wdata,
                 input io_rdata, input cpu_stall);
endinterface
`default_nettype wire

// *** nvac_dev.sv ***
// byte store with address, data and control i/o registers
//
// Design decisions made here: the placing of the registers; the APB slave port sits in nvac_host.
`timescale 1ns/1ps
`default_nettype none
module nvac_dev #(
    parameter int ADDR_W = 9,
    parameter int OSC_DIV = 5,
    parameter int ATOMIC_TICKS = 2000,
    parameter int ERASE_TICKS = 1000,
    parameter int WRITE_TICKS = 1000
) (
    input wire logic clk_sys,
    input wire logic srst,
    nvac_if.dev bus,
    output logic nv_busy
);
    import nvac_pkg::*;

    localparam int PW = 16;
    localparam int OW = $clog2(OSC_DIV);
    localparam logic [8:0] AMASK = 9'((32'd1 << ADDR_W) - 32'd1);

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] me_cnt;
        logic busy;
        logic [1:0] op;
        logic [PW-1:0] prog_cnt;
        logic [OW-1:0] osc_cnt;
        logic osc_tick;
        logic [8:0] addr;
        logic [8:0] prog_addr;
        logic [7:0] data;
        logic [7:0] prog_data;
        logic [7:0] rdata;
        logic [2:0] stall_cnt;
        logic stall;
    } nvac_dev_s;

    nvac_dev_s s_r;
    nvac_dev_s s_nxt;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic mem_we;
    logic [7:0] mem_wd;
    logic [7:0] ctrl_rd;

    assign bus.io_rdata = s_r.rdata;
    assign bus.cpu_stall = s_r.stall;
    assign nv_busy = s_r.busy;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_wd = s_r.prog_data;
        ctrl_rd = {2'b00, s_r.mode, 4'h0};
        if (s_r.me_cnt != 3'h0) begin
            ctrl_rd = ctrl_rd | CTRL_ME_M;
        end
        if (s_r.busy) begin
            ctrl_rd = ctrl_rd | CTRL_PE_M;
        end

        // programming clock derived from clk_sys divided by OSC_DIV
        s_nxt.osc_tick = 1'b0;
        if (s_r.osc_cnt == OW'(OSC_DIV - 1)) begin
            s_nxt.osc_cnt = '0;
            s_nxt.osc_tick = 1'b1;
        end else begin
            s_nxt.osc_cnt = s_r.osc_cnt + 1'b1;
        end

        if (s_r.me_cnt != 3'h0) begin
            s_nxt.me_cnt = s_r.me_cnt - 3'h1;
        end
        if (s_r.stall_cnt != 3'h0) begin
            s_nxt.stall_cnt = s_r.stall_cnt - 3'h1;
        end

        // self-timed operation; busy drops only on completion
        if (s_r.busy && s_r.osc_tick) begin
            if (s_r.prog_cnt > PW'(1)) begin
                s_nxt.prog_cnt = s_r.prog_cnt - 1'b1;
            end else begin
                s_nxt.prog_cnt = '0;
                s_nxt.busy = 1'b0;
                mem_we = 1'b1;
                unique case (s_r.op)
                    PM_ERASE: mem_wd = ERASED_BYTE;
                    // unerased target keeps only the common ones
                    PM_WRITE: mem_wd = mem[s_r.prog_addr[ADDR_W-1:0]] & s_r.prog_data;
                    default: mem_wd = s_r.prog_data;
                endcase
            end
        end

        // ------------------------------------------------------------
        // i/o register access, ignored while the cpu is held
        // ------------------------------------------------------------
        if (!s_r.stall && bus.io_we) begin
            unique case (bus.io_sel)
                REG_CTRL: begin
                    if (!s_r.busy) begin
                        s_nxt.mode = bus.io_wdata[CTRL_PM_LSB +: 2];
                    end
                    if ((bus.io_wdata & CTRL_ME_M) != 8'h00) begin
                        s_nxt.me_cnt = ME_WINDOW;
                    end
                    // start needs an open master window and an idle store
                    if ((bus.io_wdata & CTRL_PE_M) != 8'h00 && s_r.me_cnt != 3'h0
                        && !s_r.busy && s_nxt.mode != PM_RSVD) begin
                        s_nxt.busy = 1'b1;
                        s_nxt.op = s_nxt.mode;
                        s_nxt.prog_addr = s_r.addr;
                        s_nxt.prog_data = s_r.data;
                        s_nxt.me_cnt = 3'h0;
                        s_nxt.stall_cnt = WRITE_STALL;
                        unique case (s_nxt.mode)
                            PM_ERASE: s_nxt.prog_cnt = PW'(ERASE_TICKS);
                            PM_WRITE: s_nxt.prog_cnt = PW'(WRITE_TICKS);
                            default: s_nxt.prog_cnt = PW'(ATOMIC_TICKS);
                        endcase
                    end else if ((bus.io_wdata & CTRL_RE_M) != 8'h00 && !s_r.busy) begin
                        s_nxt.data = mem[s_r.addr[ADDR_W-1:0]];
                        s_nxt.stall_cnt = READ_STALL;
                    end
                end
                REG_DATA: s_nxt.data = bus.io_wdata;
                REG_ADDRL: s_nxt.addr = {s_r.addr[8], bus.io_wdata} & AMASK;
                REG_ADDRH: s_nxt.addr = {bus.io_wdata[0], s_r.addr[7:0]} & AMASK;
            endcase
        end
        if (!s_r.stall && bus.io_re) begin
            unique case (bus.io_sel)
                REG_CTRL: s_nxt.rdata = ctrl_rd;
                REG_DATA: s_nxt.rdata = s_r.data;
                REG_ADDRL: s_nxt.rdata = s_r.addr[7:0];
                REG_ADDRH: s_nxt.rdata = {7'h00, s_r.addr[8]};
            endcase
        end
        s_nxt.stall = s_nxt.stall_cnt != 3'h0;

        // ------------------------------------------------------------
        // reset lets a running operation finish
        // ------------------------------------------------------------
        if (srst) begin
            s_nxt.me_cnt = 3'h0;
            s_nxt.stall_cnt = 3'h0;
            s_nxt.stall = 1'b0;
            s_nxt.rdata = 8'h00;
            s_nxt.data = CTRL_RST;
            s_nxt.addr = 9'h000;
            if (s_r.busy) begin
                s_nxt.mode = s_r.mode;
            end else begin
                s_nxt.mode = PM_ATOMIC;
                s_nxt.busy = 1'b0;
                s_nxt.op = PM_ATOMIC;
                s_nxt.prog_cnt = '0;
                s_nxt.prog_addr = 9'h000;
                s_nxt.prog_data = 8'h00;
                s_nxt.osc_cnt = '0;
                s_nxt.osc_tick = 1'b0;
            end
            mem_we = mem_we & s_r.busy;
        end
    end

    // ----------------------------------------------------------------
    // state and array
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
        if (mem_we) begin
            mem[s_r.prog_addr[ADDR_W-1:0]] <= mem_wd;
        end
    end
endmodule
`default_nettype wire

// *** nvac_host.sv ***
// apb-commanded sequencer that drives the store's i/o registers
`timescale 1ns/1ps
`default_nettype none
module nvac_host (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    nvac_if.host bus
);
    import nvac_pkg::*;

    typedef enum logic [13:0] {
        S_IDLE = 14'h0001, S_POLL = 14'h0002, S_PCHK = 14'h0004,
        S_MODE = 14'h0008, S_ADRL = 14'h0010, S_ADRH = 14'h0020,
        S_DATA = 14'h0040, S_MEN = 14'h0080, S_PEN = 14'h0100,
        S_RSTB = 14'h0200, S_RDRD = 14'h0400, S_RCAP = 14'h0800,
        S_BUSW = 14'h1000, S_HOLD = 14'h2000
    } nvac_hst_e;

    typedef struct packed {
        nvac_hst_e st;
        nvac_hst_e ret;
        logic rd;
        logic [1:0] mode;
        logic [8:0] addr;
        logic [7:0] data;
        logic [1:0] io_sel;
        logic io_we;
        logic io_re;
        logic [7:0] io_wdata;
        logic [7:0] rbyte;
        logic busy;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } nvac_host_s;

    nvac_host_s s_r;
    nvac_host_s s_nxt;
    logic [7:0] mode_w;

    // one register access, then wait until the store lets go
    function automatic nvac_host_s acc(nvac_host_s c, logic [1:0] sel, logic we,
                                       logic [7:0] wd, nvac_hst_e r);
        acc = c;
        acc.io_sel = sel;
        acc.io_we = we;
        acc.io_re = !we;
        acc.io_wdata = wd;
        acc.ret = r;
        acc.st = S_BUSW;
    endfunction

    assign bus.io_sel = s_r.io_sel;
    assign bus.io_we = s_r.io_we;
    assign bus.io_re = s_r.io_re;
    assign bus.io_wdata = s_r.io_wdata;
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;

    always_comb begin
        s_nxt = s_r;
        mode_w = {2'b00, s_r.mode, 4'h0};
        // ------------------------------------------------------------
        // sequencer
        // ------------------------------------------------------------
        unique case (s_r.st)
            S_IDLE: s_nxt.busy = 1'b0;
            S_POLL: s_nxt = acc(s_r, REG_CTRL, 1'b0, 8'h00, S_PCHK);
            S_PCHK: begin
                if ((bus.io_rdata & CTRL_PE_M) != 8'h00) begin
                    s_nxt.st = S_POLL;
                end else begin
                    s_nxt.st = s_r.rd ? S_ADRL : S_MODE;
                end
            end
            S_MODE: s_nxt = acc(s_r, REG_CTRL, 1'b1, mode_w, S_ADRL);
            S_ADRL: s_nxt = acc(s_r, REG_ADDRL, 1'b1, s_r.addr[7:0], S_ADRH);
            S_ADRH: s_nxt = acc(s_r, REG_ADDRH, 1'b1, {7'h00, s_r.addr[8]},
                                s_r.rd ? S_RSTB : (s_r.mode == PM_ERASE ? S_MEN : S_DATA));
            // write-only relies on the caller having erased the byte
            S_DATA: s_nxt = acc(s_r, REG_DATA, 1'b1, s_r.data, S_MEN);
            // master then program enable, nothing issued between them
            S_MEN: s_nxt = acc(s_r, REG_CTRL, 1'b1, mode_w | CTRL_ME_M, S_PEN);
            S_PEN: s_nxt = acc(s_r, REG_CTRL, 1'b1, mode_w | CTRL_PE_M, S_IDLE);
            S_RSTB: s_nxt = acc(s_r, REG_CTRL, 1'b1, CTRL_RE_M, S_RDRD);
            S_RDRD: s_nxt = acc(s_r, REG_DATA, 1'b0, 8'h00, S_RCAP);
            S_RCAP: begin
                s_nxt.rbyte = bus.io_rdata;
                s_nxt.st = S_IDLE;
            end
            S_BUSW: begin
                s_nxt.io_we = 1'b0;
                s_nxt.io_re = 1'b0;
                s_nxt.st = S_HOLD;
            end
            S_HOLD: begin
                if (!bus.cpu_stall) begin
                    s_nxt.st = s_r.ret;
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase
        // ------------------------------------------------------------
        // apb slave, zero wait states
        // ------------------------------------------------------------
        s_nxt.pready = 1'b1;
        if (psel && !penable) begin
            s_nxt.pslverr = !(paddr == APB_CMD || paddr == APB_STAT);
            s_nxt.prdata = 32'h0000_0000;
            if (!pwrite && paddr == APB_STAT) begin
                s_nxt.prdata[STAT_BUSY_BIT] = s_r.busy;
                s_nxt.prdata[STAT_RBYTE_LSB +: 8] = s_r.rbyte;
            end
        end
        if (psel && penable && s_r.pready && pwrite && paddr == APB_CMD && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.rd = pwdata[CMD_RD_BIT];
            s_nxt.mode = pwdata[CMD_MODE_LSB +: 2];
            s_nxt.addr = pwdata[CMD_ADDR_LSB +: 9];
            s_nxt.data = pwdata[CMD_DATA_LSB +: 8];
            s_nxt.st = S_POLL;
        end
        if (srst) begin
            s_nxt = '0;
            s_nxt.st = S_IDLE;
            s_nxt.ret = S_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_r <= s_nxt;
    end
endmodule
`default_nettype wire

// *** nvac_asserts.sv ***
// concurrent checks on the link between the sequencer and the store
`timescale 1ns/1ps
`default_nettype none
module nvac_asserts
    import nvac_pkg::*;
#(
    parameter int OSC_DIV = 5,
    parameter int ATOMIC_TICKS = 2000
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] io_sel,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic cpu_stall,
    input wire logic nv_busy
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    localparam int BUSY_MAX = (ATOMIC_TICKS + 1) * OSC_DIV + 2;
    logic ctrl_wr;
    logic rd_start;
    logic pg_start;
    logic [2:0] win_r;
    logic [1:0] mode_r;
    int busy_cnt_r;
    assign ctrl_wr = io_we && io_sel == REG_CTRL && !cpu_stall && !srst;
    // a program enable that fails its gate falls through to the read strobe
    assign rd_start = ctrl_wr && io_wdata[0] && !nv_busy && !pg_start;
    // program enable counts only 1..4 cycles after the master enable
    assign pg_start = ctrl_wr && io_wdata[1] && !nv_busy && win_r != 3'h0 && io_wdata[5:4] != PM_RSVD;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            win_r <= 3'h0;
            busy_cnt_r <= 0;
            if (!nv_busy) begin
                mode_r <= PM_ATOMIC;
            end
        end else begin
            if (ctrl_wr && io_wdata[2]) begin
                win_r <= ME_WINDOW;
            end else if (win_r != 3'h0) begin
                win_r <= win_r - 3'h1;
            end
            if (ctrl_wr && !nv_busy) begin
                mode_r <= io_wdata[5:4];
            end
            busy_cnt_r <= nv_busy ? busy_cnt_r + 1 : 0;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    read_stall_a: assert property (rd_start |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read start did not stall four cycles");
    prog_stall_a: assert property (pg_start |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("program start did not stall two cycles");
    prog_busy_a: assert property (pg_start |=> nv_busy [*3])
        else $error("busy not held after program start");
    busy_cause_a: assert property ($rose(nv_busy) |-> $past(pg_start))
        else $error("busy rose without a gated program start");
    busy_len_a: assert property (busy_cnt_r <= BUSY_MAX)
        else $error("busy lasted too long");
    stall_cause_a: assert property ($rose(cpu_stall) |-> $past(rd_start || pg_start))
        else $error("stall without an accepted access");
    ctrl_read_a: assert property (io_re && io_sel == REG_CTRL && !cpu_stall
        |=> io_rdata[5:4] == mode_r && io_rdata[1] == $past(nv_busy))
        else $error("control read shows wrong mode or busy flag");
    lone_pe_a: assert property (ctrl_wr && io_wdata[1] && !io_wdata[0] && !pg_start |=> !cpu_stall)
        else $error("program enable without a gated start was accepted");
endmodule
`default_nettype wire

// *** test_eeprom_access_controller.sv ***
// self-checking bench: apb sequencer and byte store joined by the link
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_access_controller;
    import nvac_pkg::*;
    logic clk_sys;
    logic srst;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nv_busy;
    logic [31:0] q;
    logic e;
    int err_total;
    int comparisons;
    int n;
    logic [8:0] addrs [4] = '{9'h000, 9'h0ff, 9'h1a5, 9'h100};
    logic [7:0] dats [4] = '{8'h01, 8'h80, 8'h3c, 8'hc3};
    nvac_if link();
    nvac_dev #(.OSC_DIV(2), .ATOMIC_TICKS(3), .ERASE_TICKS(2), .WRITE_TICKS(2)) nvac_dev_i (
        .clk_sys(clk_sys), .srst(srst), .bus(link), .nv_busy(nv_busy));
    nvac_host nvac_host_i (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
    nvac_asserts #(.ATOMIC_TICKS(3)) nvac_asserts_i (.clk_sys(clk_sys), .srst(srst),
        .io_sel(link.io_sel), .io_we(link.io_we), .io_re(link.io_re), .io_wdata(link.io_wdata),
        .io_rdata(link.io_rdata), .cpu_stall(link.cpu_stall), .nv_busy(nv_busy));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
        output logic re);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (!(pready === 1'b1) && k < 50);
        if (k >= 50) check("pready wait", 32'h1, 32'h0);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle;
        logic [31:0] sq;
        logic se;
        int k;
        k = 0;
        do begin
            apb(1'b0, APB_STAT, 32'h0, sq, se);
            k++;
        end while (sq[STAT_BUSY_BIT] !== 1'b0 && k < 400);
        if (k >= 400) check("idle wait", 32'h0, 32'h1);
    endtask
    task automatic cmd(input logic [1:0] mode, input logic rd, input logic [8:0] a, input logic [7:0] d);
        logic [31:0] cq;
        logic ce;
        wait_idle();
        apb(1'b1, APB_CMD, {d, 7'h0, a, 5'h0, rd, mode}, cq, ce);
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        logic [31:0] rq;
        logic re;
        cmd(PM_ATOMIC, 1'b1, a, 8'h00);
        wait_idle();
        apb(1'b0, APB_STAT, 32'h0, rq, re);
        check("read byte", {24'h0, exp}, {24'h0, rq[15:8]});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, APB_STAT, 32'h0, q, e);
        check("busy after reset", 32'h0, {31'h0, q[STAT_BUSY_BIT]});
        apb(1'b0, 12'h008, 32'h0, q, e);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            cmd(PM_ATOMIC, 1'b0, addrs[i], dats[i]);
            apb(1'b0, APB_STAT, 32'h0, q, e);
            check("busy after start", 32'h1, {31'h0, q[STAT_BUSY_BIT]});
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(addrs[i], dats[i]);
        end
        cmd(PM_ERASE, 1'b0, 9'h1a5, 8'h00);
        rd_chk(9'h1a5, ERASED_BYTE);
        cmd(PM_WRITE, 1'b0, 9'h1a5, 8'h5a);
        rd_chk(9'h1a5, 8'h5a);
        cmd(PM_RSVD, 1'b0, 9'h000, 8'h11);
        rd_chk(9'h000, 8'h01);
        cmd(PM_ATOMIC, 1'b0, 9'h0ff, 8'h44);
        apb(1'b1, APB_CMD, {8'h99, 7'h0, 9'h0ff, 8'h00}, q, e);
        rd_chk(9'h0ff, 8'h44);
        // reset lands while the store erases; the erase must still finish
        cmd(PM_ERASE, 1'b0, 9'h100, 8'h00);
        n = 0;
        while (nv_busy !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check("busy before reset", 32'h1, {31'h0, nv_busy});
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        check("busy through reset", 32'h1, {31'h0, nv_busy});
        rd_chk(9'h100, ERASED_BYTE);
        // reset while idle clears the mode; the next poll shows it
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        cmd(PM_WRITE, 1'b0, 9'h100, 8'h6e);
        rd_chk(9'h100, 8'h6e);
        end_of_test();
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
